// File: eld_pkg.sv
// constants shared by the external line event detector
package eld_pkg;
   localparam int NUM_LINES = 16;
   localparam int NUM_PORTS = 7;
   localparam int PORT_SEL_W = 3;
   localparam int LINE_IDX_W = 4;
   localparam int NUM_SRC = NUM_LINES + 1;
   localparam int MON_LINE = NUM_LINES;
   localparam int PIN_W = NUM_PORTS * NUM_LINES;
   localparam int PIN_IDX_W = PORT_SEL_W + LINE_IDX_W;
   localparam logic [NUM_SRC-1:0] PEND_RST = 17'h00000;
   localparam logic EVT_RST = 1'h0;
   localparam logic SYNC_RST = 1'h0;
   localparam logic TOG_RST = 1'h0;
   localparam int SYNC_DEPTH = 2;
   localparam int CAPTURE_MAX = SYNC_DEPTH + 2;
endpackage

// File: eld_edge_if.sv
// link between the line controller and one edge capture cell
`timescale 1ns/1ns
interface eld_edge_if;
   logic pin;
   logic rise_seen;
   logic fall_seen;
   logic rise_wait;
   logic fall_wait;
   modport cap (
      input pin,
      output rise_seen,
      output fall_seen,
      output rise_wait,
      output fall_wait
   );
   modport ctl (
      output pin,
      input rise_seen,
      input fall_seen,
      input rise_wait,
      input fall_wait
   );
endinterface

// File: eld_edge_capture.sv
// clock-free edge catcher for one line, brought into the clk domain
`timescale 1ns/1ns
module eld_edge_capture
   import eld_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   eld_edge_if.cap lnk
);
   typedef struct packed {
      logic rs1;
      logic rs2;
      logic fs1;
      logic fs2;
      logic rref;
      logic fref;
      logic rise;
      logic fall;
   } eld_cap_st_t;

   eld_cap_st_t st_ff;
   eld_cap_st_t nxt_st;
   logic rise_tog_ff;
   logic fall_tog_ff;

   // toggles clocked by the pin itself catch pulses shorter than clk
   always_ff @(posedge lnk.pin or posedge reset) begin
      if (reset) begin
         rise_tog_ff <= TOG_RST;
      end else begin
         rise_tog_ff <= ~rise_tog_ff; // R6
      end
   end

   always_ff @(negedge lnk.pin or posedge reset) begin
      if (reset) begin
         fall_tog_ff <= TOG_RST;
      end else begin
         fall_tog_ff <= ~fall_tog_ff; // R6
      end
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.rs1 = rise_tog_ff;
      nxt_st.rs2 = st_ff.rs1;
      nxt_st.fs1 = fall_tog_ff;
      nxt_st.fs2 = st_ff.fs1;
      nxt_st.rise = st_ff.rs2 ^ st_ff.rref; // R5
      nxt_st.fall = st_ff.fs2 ^ st_ff.fref; // R5
      nxt_st.rref = st_ff.rs2;
      nxt_st.fref = st_ff.fs2;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff <= '{SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST,
                    SYNC_RST, SYNC_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign lnk.rise_seen = st_ff.rise;
   assign lnk.fall_seen = st_ff.fall;
   // seen at the pin but not yet by clk: keeps a stopped clock waking
   assign lnk.rise_wait = rise_tog_ff ^ st_ff.rref; // R7
   assign lnk.fall_wait = fall_tog_ff ^ st_ff.fref; // R7

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence seq_rise_caught;
      ##[1:4] st_ff.rise;
   endsequence

   sequence seq_fall_caught;
      ##[1:4] st_ff.fall;
   endsequence

   a_short_rise_caught: assert property ($changed(rise_tog_ff) |-> seq_rise_caught) // R6
      else $error("rising pin edge not reported within four cycles");
   a_short_fall_caught: assert property ($changed(fall_tog_ff) |-> seq_fall_caught) // R6
      else $error("falling pin edge not reported within four cycles");
endmodule

// File: eld_line_detector.sv
// external line event detector: routing, trigger select, pending and wake
// Behaviour
// (R1) any gpio pin is routed onto one of sixteen request lines
// (R2) every line has its own enable, independent of the others
// (R3) each line triggers on rising, falling or both edges
// (R4) detected requests latch into one pending register readable at once
// (R5) edge detectors raise an interrupt or event toward the processor
// (R6) pulses shorter than one clk period are still caught
// (R7) with clk stopped, a line or supply monitor edge wakes the processor
// (R8) pending stays set until cleared; irq while any enabled line pending
`timescale 1ns/1ns
module eld_line_detector
   import eld_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [PIN_W-1:0] gpio_pins,
   input wire logic supply_level_monitor,
   input wire logic [NUM_LINES*PORT_SEL_W-1:0] line_port_sel,
   input wire logic [NUM_SRC-1:0] int_enable,
   input wire logic [NUM_SRC-1:0] event_enable,
   input wire logic [NUM_SRC-1:0] rise_enable,
   input wire logic [NUM_SRC-1:0] fall_enable,
   input wire logic [NUM_SRC-1:0] sw_trigger,
   input wire logic [NUM_SRC-1:0] sw_clear,
   output logic [NUM_SRC-1:0] pending,
   output logic irq,
   output logic event_pulse,
   output logic wake_req
);
   typedef struct packed {
      logic [NUM_SRC-1:0] pend;
      logic evt;
   } eld_st_t;

   eld_st_t st_ff;
   eld_st_t nxt_st;
   logic [NUM_SRC-1:0] cap_rise;
   logic [NUM_SRC-1:0] cap_fall;
   logic [NUM_SRC-1:0] wait_rise;
   logic [NUM_SRC-1:0] wait_fall;
   logic [NUM_SRC-1:0] line_pin;
   logic [NUM_SRC-1:0] edge_hit;
   logic [NUM_SRC-1:0] wait_hit;
   logic [NUM_SRC-1:0] req_hit;

   eld_edge_if lnk [NUM_SRC] ();

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_line
         if (g < NUM_LINES) begin : g_pin
            logic [PORT_SEL_W-1:0] sel;
            logic [PIN_IDX_W-1:0] idx;
            assign sel = line_port_sel[g*PORT_SEL_W +: PORT_SEL_W];
            assign idx = {sel, LINE_IDX_W'(g)};
            // port select picks pin n of that port for line n
            assign line_pin[g] = (sel < PORT_SEL_W'(NUM_PORTS)) ? gpio_pins[idx]
                                                                 : 1'b0; // R1
         end else begin : g_mon
            assign line_pin[g] = supply_level_monitor; // R7
         end

         assign lnk[g].pin = line_pin[g];
         assign cap_rise[g] = lnk[g].rise_seen;
         assign cap_fall[g] = lnk[g].fall_seen;
         assign wait_rise[g] = lnk[g].rise_wait;
         assign wait_fall[g] = lnk[g].fall_wait;

         eld_edge_capture u_cap (
            .clk(clk),
            .reset(reset),
            .lnk(lnk[g])
         );
      end
   endgenerate

   always_comb begin
      edge_hit = (cap_rise & rise_enable) | (cap_fall & fall_enable); // R3
      wait_hit = (wait_rise & rise_enable) | (wait_fall & fall_enable); // R3
      req_hit = edge_hit | sw_trigger;
      nxt_st = st_ff;
      // a new request wins over a clear in the same cycle
      nxt_st.pend = (st_ff.pend & ~sw_clear) | (req_hit & int_enable); // R2 R4 R8
      nxt_st.evt = |(req_hit & event_enable); // R2 R5
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff <= '{PEND_RST, EVT_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pending = st_ff.pend; // R4
   assign event_pulse = st_ff.evt; // R5
   assign irq = |(st_ff.pend & int_enable); // R8
   // combinational so it works while clk is stopped
   assign wake_req = irq | (|(wait_hit & (int_enable | event_enable))); // R7

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_chk
         sequence seq_edge_taken;
            ((cap_rise[g] && rise_enable[g]) || (cap_fall[g] && fall_enable[g]))
               && int_enable[g];
         endsequence

         a_pend_sets: assert property (seq_edge_taken |=> pending[g]) // R3 R4
            else $error("selected edge did not set its pending bit");
         a_pend_holds: assert property (pending[g] && !sw_clear[g] |=> pending[g]) // R8
            else $error("pending bit dropped without a clear");
         a_line_gated: assert property ($rose(pending[g]) |-> $past(int_enable[g])) // R2
            else $error("disabled line set its pending bit");
         a_wake_level: assert property (pending[g] && int_enable[g] |-> wake_req && irq) // R7 R8
            else $error("enabled pending line gives no wake or irq");
         if (g < NUM_LINES) begin : g_route
            a_route_pin: assert property (
               line_port_sel[g*PORT_SEL_W +: PORT_SEL_W] == '0 |-> line_pin[g] == gpio_pins[g]) // R1
               else $error("line not routed from port zero pin");
         end
      end
   endgenerate

   a_irq_cause: assert property (irq |-> |(pending & int_enable)) // R8
      else $error("irq raised with no enabled pending line");
   a_event_cause: assert property (
      event_pulse |-> $past(|(((cap_rise & rise_enable) | (cap_fall & fall_enable)
                                | sw_trigger) & event_enable))) // R5
      else $error("event pulse without an enabled edge");
endmodule

// File: eld_pin_model.sv
// pin-side model: drives port pins and the supply monitor line
`timescale 1ns/1ns
module eld_pin_model
   import eld_pkg::*;
(
   output logic [PIN_W-1:0] gpio_pins,
   output logic supply_level_monitor
);
   initial begin
      gpio_pins = '0;
      supply_level_monitor = 1'h0;
   end
   // flip one pin for w ns, then flip it back
   task automatic pulse(input int idx, input int w);
      gpio_pins[idx] = ~gpio_pins[idx];
      #w gpio_pins[idx] = ~gpio_pins[idx];
   endtask
   task automatic set_pin(input int idx, input logic v);
      gpio_pins[idx] = v;
   endtask
   task automatic mon(input logic v);
      supply_level_monitor = v;
   endtask
endmodule

// File: external_line_event_detector_test.sv
// self-checking bench for the line event detector
`timescale 1ns/1ns
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module external_line_event_detector_test;
   import eld_pkg::*;
   logic clk = 1'h0;
   logic reset = 1'h0;
   logic [PIN_W-1:0] pins;
   logic mon;
   logic [NUM_LINES*PORT_SEL_W-1:0] sel = '0;
   logic [NUM_SRC-1:0] st = 17'h00000;
   logic [NUM_SRC-1:0] sc = 17'h00000;
   logic [NUM_SRC-1:0] pending;
   logic irq;
   logic ev;
   logic wake;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   eld_pin_model pm (.gpio_pins(pins), .supply_level_monitor(mon));
   eld_line_detector DUT (.clk(clk), .reset(reset), .gpio_pins(pins),
      .supply_level_monitor(mon), .line_port_sel(sel), .int_enable(17'h10068),
      .event_enable(17'h00008), .rise_enable(17'h100A0), .fall_enable(17'h00040),
      .sw_trigger(st), .sw_clear(sc), .pending(pending), .irq(irq),
      .event_pulse(ev), .wake_req(wake));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         results();
      end
   end
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic clr;
      @(posedge clk);
      sc <= 17'h1FFFF;
      @(posedge clk);
      sc <= 17'h00000;
      #1;
   endtask
   task automatic t_soft;
      @(posedge clk);
      st <= 17'h00008;
      @(posedge clk);
      st <= 17'h00000;
      #1;
      `CHK("pending", 17'h00008, pending)
      `CHK("irq", 1'h1, irq)
      `CHK("event", 1'h1, ev)
      wait_n(3);
      `CHK("event", 1'h0, ev)
      `CHK("hold", 17'h00008, pending)
      clr();
      `CHK("cleared", 17'h00000, pending)
      `CHK("irq off", 1'h0, irq)
   endtask
   task automatic t_glitch;
      wait_n(1);
      pm.pulse(37, 3);
      `CHK("wake", 1'h1, wake)
      pm.pulse(23, 3);
      wait_n(6);
      `CHK("glitch", 17'h00020, pending)
      `CHK("irq", 1'h1, irq)
      clr();
   endtask
   task automatic t_fall;
      pm.set_pin(6, 1'h1);
      wait_n(6);
      `CHK("rise ignored", 17'h00000, pending)
      pm.set_pin(6, 1'h0);
      wait_n(6);
      `CHK("fall", 17'h00040, pending)
      clr();
   endtask
   task automatic t_mon;
      pm.mon(1'h1);
      #1;
      `CHK("wake", 1'h1, wake)
      wait_n(6);
      `CHK("monitor", 17'h10000, pending)
      clr();
   endtask
   task automatic results;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      // a real rising edge on reset clears the pin-clocked toggles
      reset <= 1'h1;
      sel[15+:3] = 3'h2;
      sel[21+:3] = 3'h1;
      repeat (4) @(posedge clk);
      reset <= 1'h0;
      wait_n(1);
      t_soft();
      t_glitch();
      t_fall();
      t_mon();
      results();
   end
endmodule
